// [design/abp_defines.vh]
// constants for the byte-wide converter host port
// assumes inclusion by bare name from the design files
`ifndef ABP_DEFINES_VH
`define ABP_DEFINES_VH

`define ABP_RES_W 10
`define ABP_BUS_W 8
`define ABP_CFG_RST 8'h00
`define ABP_RES_RST 10'h000
`define ABP_CFG_EXT_ACQ_BIT 5
`define ABP_ACQ_FALLS 4
`define ABP_CONV_FALLS 12
`define ABP_INT_CLK_DIV 4
`define ABP_FIFO_DEPTH 4

`endif

// [design/abp_fifo.v]
// small flip-flop FIFO with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module abp_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // wrap by hand so depths that are not a power of two still work
  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1 || DEPTH == (1 << AW) && p == {AW{1'b1}})
        next_ptr = {AW{1'b0}};
      else
        next_ptr = p + 1'b1;
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // abp_fifo

// [design/abp_host_port.v]
// device side of a byte-wide parallel host port for a 10-bit converter
// assumes host strobes are synchronous to clk; analog result arrives on sample_value
`timescale 1ns/1ps
`include "abp_defines.vh"
module abp_host_port #(
  parameter RES_W = `ABP_RES_W,
  parameter ACQ_FALLS = `ABP_ACQ_FALLS,
  parameter CONV_FALLS = `ABP_CONV_FALLS,
  parameter INT_CLK_DIV = `ABP_INT_CLK_DIV,
  parameter FIFO_DEPTH = `ABP_FIFO_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire byte_half_select,
  input wire conv_clk,
  input wire int_clk_mode,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg [7:0] data_oe,
  output reg done_n,
  input wire [RES_W-1:0] sample_value,
  output reg [7:0] config_byte,
  output reg tracking,
  output reg converting
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ACQ_INT = 3'd1;
  localparam ST_ACQ_EXT = 3'd2;
  localparam ST_CONV = 3'd3;
  localparam ST_PUSH = 3'd4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] cfg_r;
  reg [7:0] cfg_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg [RES_W-1:0] held_r;
  reg [RES_W-1:0] held_nxt;
  reg rd_d_r;
  reg wr_d_r;
  reg clk_pin_d_r;
  reg [7:0] div_r;
  reg int_clk_r;
  reg int_clk_d_r;
  reg [RES_W-1:0] result_r;
  reg result_full_r;
  reg low_read_r;

  wire rd_fall;
  wire wr_rise;
  wire clk_fall;
  wire ext_acq;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [RES_W-1:0] fifo_out_data;

  // pins are synchronous, so one delayed copy is enough for edge detection
  assign rd_fall = ~rd_n & rd_d_r & ~cs_n;
  assign wr_rise = wr_n & ~wr_d_r & ~cs_n;
  assign ext_acq = cfg_r[`ABP_CFG_EXT_ACQ_BIT];

  // internal clock comes from a divider; the pin is then ignored
  assign clk_fall = int_clk_mode ? (int_clk_d_r & ~int_clk_r)
                                 : (clk_pin_d_r & ~conv_clk);

  function [7:0] bus_byte;
    input [RES_W-1:0] res;
    input hi;
    begin
      if (hi)
        bus_byte = {6'h00, res[9:8]};
      else
        bus_byte = res[7:0];
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      clk_pin_d_r <= 1'b0;
      div_r <= 8'h00;
      int_clk_r <= 1'b0;
      int_clk_d_r <= 1'b0;
    end else begin
      rd_d_r <= rd_n;
      wr_d_r <= wr_n;
      clk_pin_d_r <= conv_clk;
      int_clk_d_r <= int_clk_r;
      if (div_r == INT_CLK_DIV[7:0] - 8'h01) begin
        div_r <= 8'h00;
        int_clk_r <= ~int_clk_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // acquisition and conversion sequencer
  always @* begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    cnt_nxt = cnt_r;
    held_nxt = held_r;
    case (state_r)
      ST_IDLE: begin
        // a full FIFO refuses new starts, which is the back-pressure
        if (wr_rise && fifo_in_ready) begin
          cfg_nxt = data_in;
          cnt_nxt = 8'h00;
          if (data_in[`ABP_CFG_EXT_ACQ_BIT])
            state_nxt = ST_ACQ_EXT;
          else
            state_nxt = ST_ACQ_INT;
        end
      end
      ST_ACQ_INT: begin
        if (clk_fall) begin
          if (cnt_r == ACQ_FALLS[7:0] - 8'h01) begin
            held_nxt = sample_value;
            cnt_nxt = 8'h00;
            state_nxt = ST_CONV;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
      end
      ST_ACQ_EXT: begin
        if (wr_rise) begin
          held_nxt = sample_value;
          cnt_nxt = 8'h00;
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (clk_fall) begin
          if (cnt_r == CONV_FALLS[7:0] - 8'h01)
            state_nxt = ST_PUSH;
          else
            cnt_nxt = cnt_r + 8'h01;
        end
      end
      ST_PUSH: begin
        if (fifo_in_ready)
          state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign fifo_in_valid = (state_r == ST_PUSH);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cfg_r <= `ABP_CFG_RST;
      cnt_r <= 8'h00;
      held_r <= `ABP_RES_RST;
      config_byte <= `ABP_CFG_RST;
      tracking <= 1'b0;
      converting <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      cnt_r <= cnt_nxt;
      held_r <= held_nxt;
      config_byte <= cfg_nxt;
      tracking <= (state_nxt == ST_ACQ_INT) || (state_nxt == ST_ACQ_EXT);
      converting <= (state_nxt == ST_CONV) || (state_nxt == ST_PUSH);
    end
  end

  abp_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(held_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // the output slot is refilled only after the high byte has been read
  assign fifo_out_ready = ~result_full_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= `ABP_RES_RST;
      result_full_r <= 1'b0;
      low_read_r <= 1'b0;
      done_n <= 1'b1;
    end else begin
      if (!result_full_r && fifo_out_valid) begin
        result_r <= fifo_out_data;
        result_full_r <= 1'b1;
        low_read_r <= 1'b0;
        done_n <= 1'b0;
      end else if (rd_fall) begin
        done_n <= 1'b1;
        if (!byte_half_select)
          low_read_r <= 1'b1;
        else
          result_full_r <= 1'b0;
      end
    end
  end

  // bus drive follows the strobes one cycle later
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end else begin
      if (!cs_n && !rd_n) begin
        data_out <= bus_byte(result_r, byte_half_select);
        data_oe <= 8'hff;
      end else begin
        data_out <= 8'h00;
        data_oe <= 8'h00;
      end
    end
  end
endmodule // abp_host_port

// [testbench/abp_host_port_props.sv]
// assertions on abp_host_port pins
// bound to every instance; strobes sync to clk
`timescale 1ns/1ps
module abp_props (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire byte_half_select,
  input wire [7:0] data_out,
  input wire [7:0] data_oe,
  input wire done_n,
  input wire [7:0] config_byte,
  input wire tracking,
  input wire converting,
  input wire int_clk_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_hiz; cs_n |=> data_oe == 8'h00; endproperty
  a_hiz: assert property (p_hiz) else $error("bus held");
  property p_oe; !cs_n && !rd_n |=> data_oe == 8'hFF; endproperty
  a_oe: assert property (p_oe) else $error("bus idle");
  property p_hi; !cs_n && !rd_n && byte_half_select |=> data_out[7:2] == 6'h00; endproperty
  a_hi: assert property (p_hi) else $error("high byte");
  property p_dh; $fell(rd_n) && !cs_n && !byte_half_select |=> done_n; endproperty
  a_dh: assert property (p_dh) else $error("done kept");
  property p_go; $rose(tracking) |-> $past(wr_n) && !$past(wr_n, 2) && !$past(cs_n); endproperty
  a_go: assert property (p_go) else $error("bad start");
  // lower bound catches a hold counted in clk cycles instead of clock falls
  property p_ia; $rose(tracking) && !config_byte[5] |-> ##[8:40] $fell(tracking); endproperty
  a_ia: assert property (p_ia) else $error("hold time");
  // internal clock falls every eight cycles: a third or fifth fall lands outside
  property p_ic; $rose(tracking) && !config_byte[5] && int_clk_mode
    |-> ##[25:32] $fell(tracking); endproperty
  a_ic: assert property (p_ic) else $error("hold count");
  property p_ea; tracking && config_byte[5] && !cs_n && $rose(wr_n)
    |=> !tracking && converting; endproperty
  a_ea: assert property (p_ea) else $error("no hold");
  property p_dl; $fell(converting) |-> ##[0:3] !done_n; endproperty
  a_dl: assert property (p_dl) else $error("no done");
  c_hi: cover property (!cs_n && !rd_n && byte_half_select);
  c_ext: cover property ($rose(tracking) && config_byte[5]);
  c_end: cover property ($fell(converting));
endmodule // abp_props
bind abp_host_port abp_props u_p (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .byte_half_select(byte_half_select), .data_out(data_out),
  .data_oe(data_oe), .done_n(done_n), .config_byte(config_byte), .tracking(tracking),
  .converting(converting), .int_clk_mode(int_clk_mode));

// [testbench/abp_host_model.sv]
// host model: config writes, byte reads, conversion clock
// assumes tasks are called at a falling clk edge
`timescale 1ns/1ps
module abp_host_model (
  input wire clk,
  input wire ext_clk_on,
  input wire [7:0] data_out,
  input wire [7:0] data_oe,
  output reg cs_n = 1'h1,
  output reg rd_n = 1'h1,
  output reg wr_n = 1'h1,
  output reg byte_half_select = 1'h0,
  output reg [7:0] data_in = 8'h00,
  output wire conv_clk
);
  reg [1:0] div_r = 2'h0;
  always @(negedge clk) div_r <= div_r + 2'h1;
  assign conv_clk = ext_clk_on & div_r[1];
  task wr_cfg(input [7:0] cfg);
    begin
      cs_n = 1'h0;
      wr_n = 1'h0;
      data_in = cfg;
      repeat (2) @(negedge clk);
      wr_n = 1'h1;
      @(negedge clk);
      cs_n = 1'h1;
      // stale data must not look valid after release
      data_in = ~cfg;
      // idle cycle so a following call never flips cs_n in the same step
      @(negedge clk);
    end
  endtask
  task rd_byte(input hi, output [7:0] d, output [7:0] oe);
    begin
      cs_n = 1'h0;
      byte_half_select = hi;
      @(negedge clk);
      rd_n = 1'h0;
      @(negedge clk);
      d = data_out;
      oe = data_oe;
      rd_n = 1'h1;
      cs_n = 1'h1;
      @(negedge clk);
    end
  endtask
endmodule // abp_host_model

// [testbench/abp_host_port_tb_top.sv]
// bench for abp_host_port driven by the host model
// assumes checker and host model compiled first
`timescale 1ns/1ps
module abp_host_port_tb_top;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg int_clk_mode = 1'h1;
  reg [9:0] sample_value = 10'h000;
  wire cs_n, rd_n, wr_n, bhs, conv_clk, done_n, tracking, converting;
  wire [7:0] data_in, data_out, data_oe, config_byte;
  integer seed = 14;
  integer fail_count = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i, k, n;
  reg [31:0] rnd;
  reg [9:0] rq [0:7];
  reg [7:0] d, oe;
  always #25 clk = ~clk;
  abp_host_model host (.clk(clk), .ext_clk_on(~int_clk_mode), .data_out(data_out),
    .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .byte_half_select(bhs),
    .data_in(data_in), .conv_clk(conv_clk));
  abp_host_port dut (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .byte_half_select(bhs), .conv_clk(conv_clk), .int_clk_mode(int_clk_mode),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .done_n(done_n),
    .sample_value(sample_value), .config_byte(config_byte), .tracking(tracking),
    .converting(converting));
  function [7:0] exp_byte(input [9:0] r, input hi);
    exp_byte = hi ? {6'h00, r[9:8]} : r[7:0];
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    chk({4'h0, |data_oe, done_n, tracking, converting}, 8'h04);
    n = 0;
    // host never reads here, so the buffer must fill and refuse
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      sample_value = rnd[9:0];
      int_clk_mode = rnd[10];
      host.wr_cfg(rnd[18:11]);
      if (tracking === 1'h1) begin
        chk(config_byte, rnd[18:11]);
        if (rnd[16]) host.wr_cfg(8'h00);
        rq[n] = rnd[9:0];
        n = n + 1;
        // input moves once held, so a late capture shows up as a wrong byte
        for (k = 0; k < 400 && {tracking, converting} !== 2'h0; k = k + 1) begin
          @(negedge clk);
          if (converting === 1'h1) sample_value = ~rnd[9:0];
        end
      end
    end
    chk(n[7:0], 8'h05); // output slot plus a full four-deep buffer
    for (i = 0; i < n; i = i + 1) begin
      @(negedge clk);
      chk({7'h00, done_n}, 8'h00);
      host.rd_byte(1'h0, d, oe);
      chk(d, exp_byte(rq[i], 1'h0));
      chk(oe, 8'hFF);
      chk({7'h00, done_n}, 8'h01);
      host.rd_byte(1'h1, d, oe);
      chk(d, exp_byte(rq[i], 1'h1));
      chk(data_oe, 8'h00);
    end
    chk({7'h00, done_n}, 8'h01);
    give_verdict;
  end
endmodule // abp_host_port_tb_top
